// ---- rtl/fcc_pkg.sv ----
// Constants and types shared by the flash command and fault capture block
package fcc_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CLKDIV = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_OBJECT = 6'h02;
  localparam logic [5:0] IDX_FAULT = 6'h03;
  localparam logic [5:0] IDX_CAPTURE = 6'h0E;

  // Field positions
  localparam int DIVLD_BIT = 7;
  localparam int COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int ACCESS_ERROR_FLAG_BIT = 5;
  localparam int PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int DFD_BIT = 1;
  localparam int SFD_BIT = 0;
  localparam int CAPIX_LSB = 8;
  localparam int CODE_LSB = 8;
  localparam int BLOCK_BIT = 0;

  // Values after reset
  localparam logic [6:0] DIV_RESET = 7'h00;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [2:0] CAPIX_RESET = 3'h0;

  // Command codes
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0] CMD_FULL_PART = 8'h0F;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  localparam logic [7:0] CMD_EMU_ENABLE = 8'h13;
  localparam logic [7:0] CMD_EMU_DISABLE = 8'h14;
  localparam logic [7:0] CMD_EMU_QUERY = 8'h15;
  localparam logic [7:0] CMD_PARTITION = 8'h20;

  // Command sequencer states
  typedef enum logic {FCC_IDLE, FCC_RUN} fcc_state_t;

endpackage

// ---- rtl/fcc_top.sv ----
// Flash command sequencer with ECC fault capture behind an AHB-Lite slave
`timescale 1ns/100ps
module fcc_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic BUS_SLOW,
  input wire logic SPECIAL_MODE,
  output logic CMD_START,
  output logic [7:0] CMD_CODE,
  output logic CMD_BLOCK,
  input wire logic CMD_DONE,
  input wire logic CMD_PVIOL,
  output logic PT_TICK,
  input wire logic FLT_CPU_SGL,
  input wire logic FLT_CPU_DBL,
  input wire logic [22:0] FLT_CPU_ADDR,
  input wire logic [7:0] FLT_CPU_PAR,
  input wire logic [63:0] FLT_CPU_DATA,
  input wire logic FLT_COP_SGL,
  input wire logic FLT_COP_DBL,
  input wire logic [22:0] FLT_COP_ADDR,
  input wire logic [7:0] FLT_COP_PAR,
  input wire logic [63:0] FLT_COP_DATA,
  input wire logic RD_STB,
  input wire logic RD_MASTER,
  input wire logic RD_BLOCK,
  input wire logic [22:0] RD_ADDR
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bus state
  logic wr_pend, next_wr_pend; // Write data phase pending
  logic [5:0] wr_idx, next_wr_idx; // Index of pending write
  logic rd_wait, next_rd_wait; // Read wait state pending
  logic [5:0] rd_idx, next_rd_idx; // Index of pending read
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  logic accept; // Address phase taken

  // Core state
  fcc_pkg::fcc_state_t state, next_state; // Sequencer state
  logic [6:0] divide_value, next_divide_value;
  logic divider_loaded, next_divider_loaded;
  logic [6:0] tick_cnt, next_tick_cnt; // Time base counter
  logic next_pt_tick;
  logic command_complete_flag, next_command_complete_flag;
  logic access_error_flag, next_access_error_flag;
  logic protection_violation_flag, next_protection_violation_flag;
  logic [7:0] next_cmd_code;
  logic next_cmd_block;
  logic next_cmd_start;
  logic [2:0] capture_index, next_capture_index;
  logic single_fault_flag, next_single_fault_flag;
  logic double_fault_flag, next_double_fault_flag;
  logic [7:0] cap_par, next_cap_par; // Captured parity
  logic cap_master, next_cap_master; // Captured master, 1 is coprocessor
  logic [22:0] cap_addr, next_cap_addr; // Captured global address
  logic [63:0] cap_data, next_cap_data; // Captured data words 0..3
  logic [15:0] capture_view; // Indexed capture word
  logic [31:0] rd_mux; // Register read value
  logic we; // Write strobe in data phase
  logic launch; // Launch request written
  logic bad_read; // Read hits block under command
  logic use_cop; // Coprocessor fault chosen for capture

  ////////////////////////////////////////////////////////////////////////////
  // Command code helpers

  // Accepted command codes
  function automatic logic code_valid(input logic [7:0] c, input logic special);
    case (c)
      fcc_pkg::CMD_UNSECURE, fcc_pkg::CMD_USER_MARGIN, fcc_pkg::CMD_FULL_PART: code_valid = 1'b1;
      fcc_pkg::CMD_FIELD_MARGIN: code_valid = special;
      fcc_pkg::CMD_ERASE_VERIFY, fcc_pkg::CMD_PROGRAM, fcc_pkg::CMD_ERASE_SECTOR: code_valid = 1'b1;
      fcc_pkg::CMD_EMU_ENABLE, fcc_pkg::CMD_EMU_DISABLE: code_valid = 1'b1;
      fcc_pkg::CMD_EMU_QUERY, fcc_pkg::CMD_PARTITION: code_valid = 1'b1;
      default: code_valid = 1'b0;
    endcase
  endfunction

  // Codes that program or erase the arrays
  function automatic logic code_pe(input logic [7:0] c);
    case (c)
      fcc_pkg::CMD_UNSECURE, fcc_pkg::CMD_FULL_PART, fcc_pkg::CMD_PROGRAM: code_pe = 1'b1;
      fcc_pkg::CMD_ERASE_SECTOR, fcc_pkg::CMD_PARTITION: code_pe = 1'b1;
      default: code_pe = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Indexed capture view
  always_comb begin
    case (capture_index)
      3'h0: capture_view = {cap_par, cap_master, cap_addr[22:16]};
      3'h1: capture_view = cap_addr[15:0];
      3'h2: capture_view = cap_data[15:0];
      3'h3: capture_view = cap_data[31:16];
      3'h4: capture_view = cap_data[47:32];
      3'h5: capture_view = cap_data[63:48];
      default: capture_view = 16'h0000;
    endcase
  end

  // Register read multiplexer
  always_comb begin
    rd_mux = 32'h00000000;
    case (rd_idx)
      fcc_pkg::IDX_CLKDIV: begin
        rd_mux[6:0] = divide_value;
        rd_mux[fcc_pkg::DIVLD_BIT] = divider_loaded;
      end
      fcc_pkg::IDX_STATUS: begin
        rd_mux[fcc_pkg::COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag;
        rd_mux[fcc_pkg::ACCESS_ERROR_FLAG_BIT] = access_error_flag;
        rd_mux[fcc_pkg::PROTECTION_VIOLATION_FLAG_BIT] = protection_violation_flag;
      end
      fcc_pkg::IDX_OBJECT: begin
        rd_mux[fcc_pkg::CODE_LSB +: 8] = CMD_CODE;
        rd_mux[fcc_pkg::BLOCK_BIT] = CMD_BLOCK;
      end
      fcc_pkg::IDX_FAULT: begin
        rd_mux[fcc_pkg::DFD_BIT] = double_fault_flag;
        rd_mux[fcc_pkg::SFD_BIT] = single_fault_flag;
        rd_mux[fcc_pkg::CAPIX_LSB +: 3] = capture_index;
      end
      fcc_pkg::IDX_CAPTURE: rd_mux[15:0] = capture_view;
      default: rd_mux = 32'h00000000; // Unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state

  // Bus next state
  always_comb begin
    accept = HSEL & HTRANS[1] & HREADY;
    next_wr_pend = 1'b0;
    next_wr_idx = wr_idx;
    next_rd_wait = 1'b0;
    next_rd_idx = rd_idx;
    // Read data loaded after earlier writes have landed
    next_hrdata = rd_wait ? rd_mux : HRDATA;
    next_hreadyout = 1'b1;
    // Index kept for both kinds; only the pending kind uses it
    if (accept) begin
      next_wr_pend = HWRITE;
      next_wr_idx = HADDR[7:2];
      next_rd_wait = !HWRITE;
      next_rd_idx = HADDR[7:2];
      next_hreadyout = HWRITE; // Reads take one wait state
    end
  end

  // Bus registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
      rd_wait <= 1'b0;
      rd_idx <= 6'h00;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CE) begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      rd_wait <= next_rd_wait;
      rd_idx <= next_rd_idx;
      HRDATA <= next_hrdata;
      HREADYOUT <= next_hreadyout;
      HRESP <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider, command sequencer and fault capture

  // Core next state
  always_comb begin
    we = wr_pend;
    launch = we && wr_idx == fcc_pkg::IDX_STATUS && HWDATA[fcc_pkg::COMMAND_COMPLETE_FLAG_BIT];
    bad_read = RD_STB && state == fcc_pkg::FCC_RUN && RD_BLOCK == CMD_BLOCK;
    use_cop = !FLT_CPU_DBL && (FLT_COP_DBL || !FLT_CPU_SGL);
    next_state = state;
    next_divide_value = divide_value;
    next_divider_loaded = divider_loaded;
    next_tick_cnt = tick_cnt;
    next_pt_tick = 1'b0;
    next_command_complete_flag = command_complete_flag;
    next_access_error_flag = access_error_flag;
    next_protection_violation_flag = protection_violation_flag;
    next_cmd_code = CMD_CODE;
    next_cmd_block = CMD_BLOCK;
    next_cmd_start = 1'b0;
    next_capture_index = capture_index;
    next_single_fault_flag = single_fault_flag;
    next_double_fault_flag = double_fault_flag;
    next_cap_par = cap_par;
    next_cap_master = cap_master;
    next_cap_addr = cap_addr;
    next_cap_data = cap_data;
    // Time base from the oscillator clock, divide by value plus one
    if (divider_loaded) begin
      next_pt_tick = tick_cnt >= divide_value;
      next_tick_cnt = next_pt_tick ? 7'h00 : tick_cnt + 7'h01;
    end
    // Divider write
    if (we && wr_idx == fcc_pkg::IDX_CLKDIV) begin
      next_divide_value = HWDATA[6:0];
      next_divider_loaded = 1'b1;
      next_tick_cnt = 7'h00;
    end
    // Object write only while idle
    if (we && wr_idx == fcc_pkg::IDX_OBJECT && command_complete_flag) begin
      next_cmd_code = HWDATA[fcc_pkg::CODE_LSB +: 8];
      next_cmd_block = HWDATA[fcc_pkg::BLOCK_BIT];
    end
    // Fault control write, capture index and flag clears
    if (we && wr_idx == fcc_pkg::IDX_FAULT) begin
      next_capture_index = HWDATA[fcc_pkg::CAPIX_LSB +: 3];
      next_double_fault_flag = double_fault_flag & ~HWDATA[fcc_pkg::DFD_BIT];
      next_single_fault_flag = single_fault_flag & ~HWDATA[fcc_pkg::SFD_BIT];
    end
    // Error flag clears, write one to clear
    if (we && wr_idx == fcc_pkg::IDX_STATUS) begin
      next_access_error_flag = access_error_flag & ~HWDATA[fcc_pkg::ACCESS_ERROR_FLAG_BIT];
      next_protection_violation_flag = protection_violation_flag & ~HWDATA[fcc_pkg::PROTECTION_VIOLATION_FLAG_BIT];
    end
    // Sequencer
    case (state)
      fcc_pkg::FCC_IDLE: begin
        // Launch only when idle and both error flags clear
        if (launch && command_complete_flag && !access_error_flag && !protection_violation_flag) begin
          if (!code_valid(CMD_CODE, SPECIAL_MODE)) begin
            next_access_error_flag = 1'b1;
          end else if (code_pe(CMD_CODE) && !divider_loaded) begin
            next_access_error_flag = 1'b1;
          end else if (code_pe(CMD_CODE) && BUS_SLOW) begin
            next_access_error_flag = 1'b1;
          end else begin
            next_state = fcc_pkg::FCC_RUN;
            next_command_complete_flag = 1'b0;
            next_cmd_start = 1'b1;
          end
        end
      end
      fcc_pkg::FCC_RUN: begin
        // Finish reported by the array
        if (CMD_DONE) begin
          next_state = fcc_pkg::FCC_IDLE;
          next_command_complete_flag = 1'b1;
          next_protection_violation_flag = next_protection_violation_flag | CMD_PVIOL;
        end
      end
      default: next_state = fcc_pkg::FCC_IDLE;
    endcase
    // Capture only while no fault is held; a fault in the cycle that clears a held fault is lost
    if (!single_fault_flag && !double_fault_flag) begin
      if (FLT_CPU_DBL || FLT_COP_DBL || FLT_CPU_SGL || FLT_COP_SGL) begin
        // Double beats single, then main processor beats coprocessor
        next_double_fault_flag = FLT_CPU_DBL || FLT_COP_DBL;
        next_single_fault_flag = !(FLT_CPU_DBL || FLT_COP_DBL);
        next_cap_par = use_cop ? FLT_COP_PAR : FLT_CPU_PAR;
        next_cap_master = use_cop;
        next_cap_addr = use_cop ? FLT_COP_ADDR : FLT_CPU_ADDR;
        next_cap_data = use_cop ? FLT_COP_DATA : FLT_CPU_DATA;
      end else if (bad_read) begin
        // Invalid read: both flags, master and address only
        next_single_fault_flag = 1'b1;
        next_double_fault_flag = 1'b1;
        next_cap_par = 8'h00;
        next_cap_master = RD_MASTER;
        next_cap_addr = RD_ADDR;
        next_cap_data = 64'h0000000000000000;
      end
    end
  end

  // Core registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= fcc_pkg::FCC_IDLE;
      divide_value <= fcc_pkg::DIV_RESET;
      divider_loaded <= 1'b0;
      tick_cnt <= 7'h00;
      PT_TICK <= 1'b0;
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
      CMD_CODE <= fcc_pkg::CODE_RESET;
      CMD_BLOCK <= 1'b0;
      CMD_START <= 1'b0;
      capture_index <= fcc_pkg::CAPIX_RESET;
      single_fault_flag <= 1'b0;
      double_fault_flag <= 1'b0;
      cap_par <= 8'h00;
      cap_master <= 1'b0;
      cap_addr <= 23'h000000;
      cap_data <= 64'h0000000000000000;
    end else if (CE) begin
      state <= next_state;
      divide_value <= next_divide_value;
      divider_loaded <= next_divider_loaded;
      tick_cnt <= next_tick_cnt;
      PT_TICK <= next_pt_tick;
      command_complete_flag <= next_command_complete_flag;
      access_error_flag <= next_access_error_flag;
      protection_violation_flag <= next_protection_violation_flag;
      CMD_CODE <= next_cmd_code;
      CMD_BLOCK <= next_cmd_block;
      CMD_START <= next_cmd_start;
      capture_index <= next_capture_index;
      single_fault_flag <= next_single_fault_flag;
      double_fault_flag <= next_double_fault_flag;
      cap_par <= next_cap_par;
      cap_master <= next_cap_master;
      cap_addr <= next_cap_addr;
      cap_data <= next_cap_data;
    end
  end

endmodule

// ---- tb/fcc_chk.sv ----
// Port checks for the flash command and fault capture block
`timescale 1ns/100ps
module fcc_chk (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic BUS_SLOW,
  input wire logic SPECIAL_MODE,
  input wire logic CMD_START,
  input wire logic [7:0] CMD_CODE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Transfer accepted on the bus
  wire logic take = HSEL && HTRANS[1] && HREADY;
  ////////////////////////////////////////
  property p_rd_wait;
    take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_nowait;
    take && HWRITE |=> HREADYOUT;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_okay;
    HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rdata_hold;
    !$rose(HREADYOUT) |-> $stable(HRDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_start_cause;
    CMD_START |-> $past(HWDATA[7]) && $past(take && HWRITE && HADDR[7:2] == fcc_pkg::IDX_STATUS, 2);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without launch");
  property p_code_valid;
    CMD_START |-> CMD_CODE inside {8'h0B, [8'h0D:8'h15], 8'h20};
  endproperty
  a_code_valid: assert property (p_code_valid) else $error("invalid code started");
  property p_field_margin;
    CMD_START && CMD_CODE == 8'h0E |-> $past(SPECIAL_MODE);
  endproperty
  a_field_margin: assert property (p_field_margin) else $error("margin outside special");
  property p_slow_block;
    CMD_START && CMD_CODE inside {8'h0B, 8'h0F, 8'h11, 8'h12, 8'h20} |-> !$past(BUS_SLOW);
  endproperty
  a_slow_block: assert property (p_slow_block) else $error("program on slow bus");
endmodule

bind fcc_top fcc_chk u_chk (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .BUS_SLOW(BUS_SLOW), .SPECIAL_MODE(SPECIAL_MODE), .CMD_START(CMD_START),
  .CMD_CODE(CMD_CODE));

// ---- tb/fcc_array_model.sv ----
// Behavioural flash array answering launched commands after a short or long run
`timescale 1ns/100ps
module fcc_array_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic long_run,
  input wire logic pviol_req,
  output logic done,
  output logic pviol
);
  // Cycles left in the running command
  int remain;
  // Changing level shown while no result is offered
  logic toggle;
  // Run counter and done pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain <= 0;
      done <= 1'b0;
      toggle <= 1'b0;
    end else begin
      toggle <= ~toggle;
      done <= (remain == 1);
      if (start) begin
        remain <= long_run ? 40 : 2;
      end else if (remain > 0) begin
        remain <= remain - 1;
      end
    end
  end
  // Violation only meaningful beside done
  assign pviol = done ? pviol_req : toggle;
endmodule

// ---- tb/fcc_top_tb.sv ----
// Self-checking bench for the flash command and fault capture block
`timescale 1ns/100ps
module fcc_top_tb;
  logic REF_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, BUS_SLOW, SPECIAL_MODE;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS;
  logic CMD_START, CMD_BLOCK, CMD_DONE, CMD_PVIOL, PT_TICK;
  logic [7:0] CMD_CODE, CPU_PAR, COP_PAR;
  logic CPU_SGL, CPU_DBL, COP_SGL, COP_DBL, RD_STB, RD_MASTER, RD_BLOCK;
  logic [22:0] CPU_ADDR, COP_ADDR, RD_ADDR;
  logic [63:0] CPU_DATA, COP_DATA;
  // Bench state
  logic long_run, pviol_req, rd_pend, st_blk, blk;
  logic [7:0] st_code;
  logic [31:0] exp_q[$];
  string name_q[$];
  int errors = 0, num_checks = 0, starts = 0, dones = 0, ticks = 0, seed, t0;
  logic [7:0] codes [11] = '{8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h20};
  logic [7:0] bad [3] = '{8'h0C, 8'h0E, 8'h12};
  localparam logic [31:0] A_DIV = {24'h000000, fcc_pkg::IDX_CLKDIV, 2'h0};
  localparam logic [31:0] A_STS = {24'h000000, fcc_pkg::IDX_STATUS, 2'h0};
  localparam logic [31:0] A_OBJ = {24'h000000, fcc_pkg::IDX_OBJECT, 2'h0};
  localparam logic [31:0] A_FLT = {24'h000000, fcc_pkg::IDX_FAULT, 2'h0};
  localparam logic [31:0] A_CAP = {24'h000000, fcc_pkg::IDX_CAPTURE, 2'h0};
  ////////////////////////////////////////
  fcc_top u_dut (.REF_CLK(REF_CLK), .RST(RST), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BUS_SLOW(BUS_SLOW), .SPECIAL_MODE(SPECIAL_MODE),
    .CMD_START(CMD_START), .CMD_CODE(CMD_CODE), .CMD_BLOCK(CMD_BLOCK), .CMD_DONE(CMD_DONE),
    .CMD_PVIOL(CMD_PVIOL), .PT_TICK(PT_TICK), .FLT_CPU_SGL(CPU_SGL), .FLT_CPU_DBL(CPU_DBL),
    .FLT_CPU_ADDR(CPU_ADDR), .FLT_CPU_PAR(CPU_PAR), .FLT_CPU_DATA(CPU_DATA), .FLT_COP_SGL(COP_SGL),
    .FLT_COP_DBL(COP_DBL), .FLT_COP_ADDR(COP_ADDR), .FLT_COP_PAR(COP_PAR), .FLT_COP_DATA(COP_DATA),
    .RD_STB(RD_STB), .RD_MASTER(RD_MASTER), .RD_BLOCK(RD_BLOCK), .RD_ADDR(RD_ADDR));
  fcc_array_model u_arr (.clk(REF_CLK), .rst(RST), .start(CMD_START), .long_run(long_run),
    .pviol_req(pviol_req), .done(CMD_DONE), .pviol(CMD_PVIOL));
  // Clock
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // Output watcher: read results, starts, dones, ticks
  always @(posedge REF_CLK) begin
    if (rd_pend && HREADYOUT === 1'b1) begin
      rd_pend = 1'b0;
      check(name_q.pop_front(), HRDATA, exp_q.pop_front());
    end
    if (HSEL && HTRANS[1] && !HWRITE && HREADYOUT === 1'b1) begin
      rd_pend = 1'b1;
    end
    if (CMD_START === 1'b1) begin
      starts++;
      st_code = CMD_CODE;
      st_blk = CMD_BLOCK;
    end
    dones += int'(CMD_DONE === 1'b1);
    ticks += int'(PT_TICK === 1'b1);
  end
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait for ready
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask
  // One single word transfer
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    wait_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_ready();
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic launch(input logic [7:0] c, input logic b);
    bus(A_OBJ, 1'b1, {16'h0000, c, 7'h00, b});
    bus(A_STS, 1'b1, 32'h00000080);
  endtask
  task automatic wait_done(input int target);
    int n;
    n = 0;
    while (dones < target && n < 100) begin
      @(posedge REF_CLK);
      n++;
    end
    if (dones < target) begin
      errors++;
      print_verdict();
    end
  endtask
  // Fault strobes {cpu sgl, cpu dbl, cop sgl, cop dbl} with fresh fields
  task automatic fault(input logic [3:0] s);
    @(posedge REF_CLK);
    {CPU_SGL, CPU_DBL, COP_SGL, COP_DBL} <= s;
    if (s[3:2] != 2'b00) begin
      CPU_ADDR <= 23'($random(seed));
      CPU_PAR <= 8'($random(seed));
      CPU_DATA <= {$random(seed), $random(seed)};
    end
    if (s[1:0] != 2'b00) begin
      COP_ADDR <= 23'($random(seed));
      COP_PAR <= 8'($random(seed));
      COP_DATA <= {$random(seed), $random(seed)};
    end
    @(posedge REF_CLK);
    {CPU_SGL, CPU_DBL, COP_SGL, COP_DBL} <= 4'h0;
  endtask
  function automatic logic [31:0] cap(input int i, input logic m, input logic [22:0] a, input logic [7:0] p,
    input logic [63:0] d);
    case (i)
      0: cap = {16'h0000, p, m, a[22:16]};
      1: cap = {16'h0000, a[15:0]};
      2, 3, 4, 5: cap = {16'h0000, d[16*(i-2) +: 16]};
      default: cap = 32'h0;
    endcase
  endfunction
  // Read every capture index
  task automatic sweep(input logic m, input logic [22:0] a, input logic [7:0] p, input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      bus(A_FLT, 1'b1, {21'h0, i[2:0], 8'h00});
      rd("capture", A_CAP, cap(i, m, a, p, d));
    end
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 92;
    {RST, HSEL, HWRITE, BUS_SLOW, SPECIAL_MODE, long_run, pviol_req, rd_pend} = 8'h80;
    {CPU_SGL, CPU_DBL, COP_SGL, COP_DBL, RD_STB, RD_MASTER, RD_BLOCK, HTRANS} = 9'h000;
    {HADDR, HWDATA, CPU_DATA, COP_DATA, CPU_ADDR, COP_ADDR, RD_ADDR, CPU_PAR, COP_PAR} = '0;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    rd("status", A_STS, 32'h80);
    rd("divider", A_DIV, 32'h00);
    rd("unmapped", 32'h00000040, 32'h0);
    launch(8'h11, 1'b0);
    rd("status", A_STS, 32'hA0);
    launch(8'h10, 1'b0);
    rd("status", A_STS, 32'hA0);
    bus(A_STS, 1'b1, 32'h20);
    bus(A_DIV, 1'b1, 32'h05);
    rd("divider", A_DIV, 32'h85);
    t0 = ticks;
    repeat (60) @(posedge REF_CLK);
    check("ticks", ticks - t0, 10);
    for (int k = 0; k < 3; k++) begin
      @(posedge REF_CLK);
      BUS_SLOW <= (k == 2);
      launch(bad[k], 1'b0);
      rd("status", A_STS, 32'hA0);
      bus(A_STS, 1'b1, 32'h20);
    end
    check("starts", starts, 0);
    @(posedge REF_CLK);
    BUS_SLOW <= 1'b0;
    SPECIAL_MODE <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      long_run = k[0];
      blk = 1'($random(seed));
      launch(codes[k], blk);
      if (long_run) begin
        rd("status", A_STS, 32'h00);
        bus(A_OBJ, 1'b1, 32'h00001400);
        bus(A_STS, 1'b1, 32'h80);
        rd("object", A_OBJ, {16'h0000, codes[k], 7'h00, blk});
      end
      wait_done(k + 1);
      check("start", {16'(starts), st_code, 7'h00, st_blk}, {16'(k + 1), codes[k], 7'h00, blk});
      rd("status", A_STS, 32'h80);
    end
    pviol_req = 1'b1;
    launch(8'h0D, 1'b0);
    wait_done(12);
    rd("status", A_STS, 32'h90);
    pviol_req = 1'b0;
    launch(8'h0D, 1'b0);
    rd("status", A_STS, 32'h90);
    bus(A_STS, 1'b1, 32'h10);
    check("starts", starts, 12);
    fault(4'b1001);
    rd("fault", A_FLT, 32'h2);
    sweep(1'b1, COP_ADDR, COP_PAR, COP_DATA);
    fault(4'b0100);
    bus(A_CAP, 1'b1, 32'h0000FFFF);
    sweep(1'b1, COP_ADDR, COP_PAR, COP_DATA);
    bus(A_FLT, 1'b1, 32'h3);
    rd("fault", A_FLT, 32'h0);
    fault(4'b0101);
    sweep(1'b0, CPU_ADDR, CPU_PAR, CPU_DATA);
    bus(A_FLT, 1'b1, 32'h3);
    long_run = 1'b1;
    launch(8'h15, 1'b1);
    @(posedge REF_CLK);
    {RD_STB, RD_MASTER, RD_BLOCK} <= 3'h7;
    RD_ADDR <= 23'($random(seed));
    @(posedge REF_CLK);
    RD_STB <= 1'b0;
    wait_done(13);
    rd("fault", A_FLT, 32'h3);
    sweep(1'b1, RD_ADDR, 8'h00, 64'h0);
    // Second reset: divider forgotten, sector erase refused again
    @(posedge REF_CLK);
    RST <= 1'b1;
    @(posedge REF_CLK);
    RST <= 1'b0;
    rd("divider", A_DIV, 32'h00);
    rd("fault", A_FLT, 32'h0);
    launch(8'h12, 1'b0);
    rd("status", A_STS, 32'hA0);
    check("starts", starts, 13);
    print_verdict();
  end
endmodule
